// File: sig_ctl_device.sv
// Summary of operation
// - Independent half-dB attenuation, 0 to -127.5 dB
// - Follow flag applies channel A volume
// - Soft ramp moves in 1/8 dB steps
// - PCM mode 2 ramps near 1 dB/ms
// - Bitstream path ramps near 1 dB/ms
// - Separate invert bit per channel
// - Swap exchanges left and right
// - Copy drives channel B from A
// - Filter change uses dedicated PCM ramp-down
// - Dedicated ramp-up after stream errors
// - Mute both or each channel alone
// - Auto-mute on recognised idle pattern
// - Mirror applies PCM routing, mute and ramp settings to bitstream; volumes stay the bitstream's own
// - Direct bitstream bypass, no volume
// - Boost only at top scale with high rail
// - Host changes wideband only while powered down
// - Wideband needs 192 kHz and no non-oversampling, checked only while powered down
// - Host changes chain only while powered down
// - Ports power down only after done event
// - Reset returns everything to defaults
`timescale 1ns/10ps
`include "sig_ctl_params.svh"
module sig_ctl_device #(
  parameter int W = `SAMPLE_WIDTH,
  parameter int STEP_CYCLES = `RAMP_STEP_CYCLES,
  parameter int MUTE_SAMPLES = `AUTO_MUTE_SAMPLES
) (
  input wire logic core_clk,
  input wire logic rst,
  sig_ctl_if.device link,
  input wire logic pcm_valid,
  input wire logic signed [W-1:0] pcm_a,
  input wire logic signed [W-1:0] pcm_b,
  input wire logic bs_valid,
  input wire logic bs_a,
  input wire logic bs_b,
  input wire logic bs_error,
  output logic out_valid,
  output logic signed [W-1:0] out_a,
  output logic signed [W-1:0] out_b,
  output logic bs_out_valid,
  output logic signed [W-1:0] bs_out_a,
  output logic signed [W-1:0] bs_out_b,
  output logic direct_valid,
  output logic direct_a,
  output logic direct_b,
  output logic [1:0] full_scale_level,
  output logic boost_active,
  output logic wideband_active,
  output logic [1:0] filter_active
);
  import sig_ctl_pkg::*;

  localparam int LW = 10;
  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam int MW = $clog2(MUTE_SAMPLES + 1);
  localparam int PA = 0;
  localparam int PB = 1;
  localparam int BA = 2;
  localparam int BB = 3;
  localparam logic [LW-1:0] FLOOR = `LEVEL_FLOOR;
  localparam logic signed [W-1:0] BS_HIGH = {2'b01, {(W-2){1'b0}}};

  // Gain mantissa for 0.75 dB sub-steps of one 6 dB octave
  function automatic logic [15:0] mant(input logic [2:0] fr);
    case (fr)
      3'h0: mant = 16'h8000;
      3'h1: mant = 16'h7560;
      3'h2: mant = 16'h6BA2;
      3'h3: mant = 16'h62B3;
      3'h4: mant = 16'h5A82;
      3'h5: mant = 16'h52FF;
      3'h6: mant = 16'h4C1C;
      default: mant = 16'h45CB;
    endcase
  endfunction

  // Shift-and-multiply gain; sub-step error stays below 0.75 dB
  function automatic logic signed [W-1:0] scale(input logic signed [W-1:0] s,
                                                input logic [LW-1:0] lvl);
    logic [4:0] sh;
    logic [2:0] fr;
    logic signed [W+16:0] prod;
    sh = 5'(lvl / `LEVELS_PER_SHIFT);
    fr = 3'((lvl % `LEVELS_PER_SHIFT) / `LEVELS_PER_FRAC);
    prod = s * $signed({1'b0, mant(fr)});
    prod = prod >>> (`MANT_FRAC_BITS + sh);
    return prod[W-1:0];
  endfunction

  // Swap, copy, invert and mute of one channel pair
  function automatic logic [2*W-1:0] route(input logic signed [W-1:0] a,
                                           input logic signed [W-1:0] b,
                                           input path_ctl_t c,
                                           input logic am);
    logic signed [W-1:0] ra;
    logic signed [W-1:0] rb;
    ra = c.swap_channels ? b : a;
    rb = c.copy_a_to_b ? ra : (c.swap_channels ? a : b);
    if (c.invert_channel_a) ra = -ra;
    if (c.invert_channel_b) rb = -rb;
    if (c.mute_a | am) ra = '0;
    if (c.mute_b | am) rb = '0;
    return {ra, rb};
  endfunction

  logic [LW-1:0] level_reg [4];
  logic [LW-1:0] target [4];
  logic [7:0] code [4];
  logic ramp_en [4];
  logic [CW-1:0] step_cnt_reg;
  logic [MW-1:0] pcm_idle_reg;
  logic [MW-1:0] bs_idle_reg;
  logic bs_prev_a_reg;
  logic bs_prev_b_reg;
  logic bs_recover_reg;
  filt_state_t filt_state_reg;
  status_word_t status_reg;

  // Effective bitstream settings
  path_ctl_t bs_eff;
  wire pdn = link.ctrl.playback_power_down;
  wire mirror = link.ctrl.mirror_pcm_settings;
  wire direct = link.ctrl.direct_bypass;
  assign bs_eff = mirror ? link.pcm_ctl : link.bs_ctl;
  wire pcm_soft = link.pcm_ctl.volume_change_mode == `MODE_SOFT_RAMP;
  wire bs_soft = mirror ? pcm_soft : (link.bs_ctl.volume_change_mode == `BS_MODE_RAMP);
  wire recover_en = mirror ? link.ctrl.pcm_ramp_down_enable
                           : link.ctrl.stream_error_recovery_ramp;
  wire filt_down = filt_state_reg == FILT_DOWN;
  wire filt_ramp = filt_state_reg != FILT_IDLE;
  wire tick = step_cnt_reg == CW'(STEP_CYCLES - 1);

  // Volume codes; B may follow A
  assign code[PA] = link.pcm_ctl.volume_a;
  assign code[PB] = link.pcm_ctl.volume_b_follows_a ? link.pcm_ctl.volume_a
                                                     : link.pcm_ctl.volume_b;
  assign code[BA] = link.bs_ctl.volume_a;
  assign code[BB] = bs_eff.volume_b_follows_a ? link.bs_ctl.volume_a
                                               : link.bs_ctl.volume_b;

  // Targets in 1/8 dB units; filter ramp-down drives PCM to the floor
  assign target[PA] = filt_down ? FLOOR : {code[PA], 2'b00};
  assign target[PB] = filt_down ? FLOOR : {code[PB], 2'b00};
  assign target[BA] = {code[BA], 2'b00};
  assign target[BB] = {code[BB], 2'b00};
  assign ramp_en[PA] = pcm_soft | filt_ramp;
  assign ramp_en[PB] = pcm_soft | filt_ramp;
  assign ramp_en[BA] = bs_soft | bs_recover_reg;
  assign ramp_en[BB] = bs_soft | bs_recover_reg;

  wire pcm_busy = (level_reg[PA] != target[PA]) | (level_reg[PB] != target[PB]);
  wire bs_busy = (level_reg[BA] != target[BA]) | (level_reg[BB] != target[BB]);
  wire pcm_am = link.pcm_ctl.auto_mute & (pcm_idle_reg == MW'(MUTE_SAMPLES));
  wire bs_am = bs_eff.auto_mute & (bs_idle_reg == MW'(MUTE_SAMPLES));
  wire pcm_zero = (pcm_a == '0) & (pcm_b == '0);
  wire bs_alt = (bs_a != bs_prev_a_reg) & (bs_b != bs_prev_b_reg);

  // Routed pairs; one-bit input maps to plus or minus half scale
  wire signed [W-1:0] bs_sa = bs_a ? BS_HIGH : -BS_HIGH;
  wire signed [W-1:0] bs_sb = bs_b ? BS_HIGH : -BS_HIGH;
  wire [2*W-1:0] pcm_rt = route(pcm_a, pcm_b, link.pcm_ctl, pcm_am);
  wire [2*W-1:0] bs_rt = route(bs_sa, bs_sb, bs_eff, bs_am);

  // Shared step timer; one tick per 1/8 dB step
  always_ff @(posedge core_clk) begin
    if (rst | tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + CW'(1);
    end
  end

  // Level trackers; retargeting continues from the present level
  for (genvar i = 0; i < 4; i++) begin : g_level
    always_ff @(posedge core_clk) begin
      if (rst) begin
        level_reg[i] <= '0;
      end else if (i >= BA && bs_error) begin
        level_reg[i] <= FLOOR;
      end else if (!ramp_en[i]) begin
        level_reg[i] <= target[i];
      end else if (tick && level_reg[i] > target[i]) begin
        level_reg[i] <= level_reg[i] - LW'(1);
      end else if (tick && level_reg[i] < target[i]) begin
        level_reg[i] <= level_reg[i] + LW'(1);
      end
    end
  end

  // Recovery ramp flag; a new error wins over completion
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bs_recover_reg <= 1'b0;
    end else if (bs_error & recover_en) begin
      bs_recover_reg <= 1'b1;
    end else if (!bs_error && !bs_busy) begin
      bs_recover_reg <= 1'b0;
    end
  end

  // Filter switch: ramp down, swap filter, ramp back up
  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_state_reg <= FILT_IDLE;
      filter_active <= '0;
    end else begin
      case (filt_state_reg)
        FILT_IDLE: begin
          if (link.ctrl.filter_select != filter_active) begin
            if (link.ctrl.pcm_ramp_down_enable && !pdn) begin
              filt_state_reg <= FILT_DOWN;
            end else begin
              filter_active <= link.ctrl.filter_select;
            end
          end
        end
        FILT_DOWN: begin
          if (level_reg[PA] == FLOOR && level_reg[PB] == FLOOR) begin
            filter_active <= link.ctrl.filter_select;
            filt_state_reg <= FILT_UP;
          end
        end
        FILT_UP: begin
          if (!pcm_busy) begin
            filt_state_reg <= FILT_IDLE;
          end
        end
        default: filt_state_reg <= FILT_IDLE;
      endcase
    end
  end

  // Idle-pattern counters: all-zero PCM, alternating bitstream
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pcm_idle_reg <= '0;
      bs_idle_reg <= '0;
      bs_prev_a_reg <= 1'b0;
      bs_prev_b_reg <= 1'b1;
    end else begin
      if (pcm_valid) begin
        pcm_idle_reg <= !pcm_zero ? '0 : (pcm_am ? pcm_idle_reg : pcm_idle_reg + MW'(1));
      end
      if (bs_valid) begin
        bs_idle_reg <= !bs_alt ? '0 : (bs_am ? bs_idle_reg : bs_idle_reg + MW'(1));
        bs_prev_a_reg <= bs_a;
        bs_prev_b_reg <= bs_b;
      end
    end
  end

  // PCM output stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_a <= '0;
      out_b <= '0;
    end else begin
      out_valid <= pcm_valid & !pdn;
      if (pcm_valid & !pdn) begin
        out_a <= scale(pcm_rt[2*W-1:W], level_reg[PA]);
        out_b <= scale(pcm_rt[W-1:0], level_reg[PB]);
      end
    end
  end

  // Bitstream output stage; bypass skips volume entirely
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bs_out_valid <= 1'b0;
      bs_out_a <= '0;
      bs_out_b <= '0;
      direct_valid <= 1'b0;
      direct_a <= 1'b0;
      direct_b <= 1'b0;
    end else begin
      bs_out_valid <= bs_valid & !pdn & !direct;
      direct_valid <= bs_valid & !pdn & direct;
      if (bs_valid & !pdn & !direct) begin
        bs_out_a <= bs_error ? '0 : scale(bs_rt[2*W-1:W], level_reg[BA]);
        bs_out_b <= bs_error ? '0 : scale(bs_rt[W-1:0], level_reg[BB]);
      end
      if (bs_valid & !pdn & direct) begin
        direct_a <= bs_a;
        direct_b <= bs_b;
      end
    end
  end

  // Analog-side settings and status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      full_scale_level <= '0;
      boost_active <= 1'b0;
      wideband_active <= 1'b0;
      status_reg <= '0;
    end else begin
      full_scale_level <= link.ctrl.full_scale_select;
      boost_active <= link.ctrl.one_db_boost_enable & link.ctrl.high_voltage_rail_enable
                      & (link.ctrl.full_scale_select == `FS_TOP);
      wideband_active <= link.ctrl.wideband_flat_enable;
      status_reg.power_down_done_event <= pdn & !out_valid & !bs_out_valid & !direct_valid;
      status_reg.pcm_ramp_busy <= pcm_busy;
      status_reg.bs_ramp_busy <= bs_busy;
      status_reg.pcm_auto_muted <= pcm_am;
      status_reg.bs_auto_muted <= bs_am;
    end
  end

  assign link.status = status_reg;

endmodule // sig_ctl_device

// File: sig_ctl_params.svh
`ifndef SIG_CTL_PARAMS_SVH
`define SIG_CTL_PARAMS_SVH

// Clock and ramp timing
`define CLK_PERIOD_NS 8
// One 1/8 dB step at 1 dB/ms
`define RAMP_STEP_NS 125000
`define RAMP_STEP_CYCLES (`RAMP_STEP_NS / `CLK_PERIOD_NS)

// Consecutive idle samples before auto-mute
`define AUTO_MUTE_SAMPLES 8192
`define SAMPLE_WIDTH 24

// Attenuation level in 1/8 dB units
`define LEVEL_FLOOR 10'h3FC
`define LEVELS_PER_SHIFT 48
`define LEVELS_PER_FRAC 6
`define MANT_FRAC_BITS 15

// Mode codes
`define MODE_SOFT_RAMP 2'h2
`define BS_MODE_RAMP 2'h1
`define FS_TOP 2'h3
`define NON_OVERSAMPLING_FILTER 2'h3

// Register map
`define REG_CTRL 8'h00
`define REG_PCM 8'h04
`define REG_BS 8'h08
`define REG_STATUS 8'h0C
`define REG_PORTS 8'h10

// Reset values
`define CTRL_RESET 32'h0000_0001
`define PATH_RESET 32'h0000_0000
`define PORTS_RESET 2'h0

`endif

// File: sig_ctl_pkg.sv
package sig_ctl_pkg;

  // Per-path signal control word
  typedef struct packed {
    logic [5:0] unused;
    logic auto_mute;
    logic copy_a_to_b;
    logic swap_channels;
    logic invert_channel_b;
    logic invert_channel_a;
    logic mute_b;
    logic mute_a;
    logic [1:0] volume_change_mode;
    logic volume_b_follows_a;
    logic [7:0] volume_b;
    logic [7:0] volume_a;
  } path_ctl_t;

  // Global control word
  typedef struct packed {
    logic [19:0] unused;
    logic [1:0] filter_select;
    logic stream_error_recovery_ramp;
    logic pcm_ramp_down_enable;
    logic one_db_boost_enable;
    logic high_voltage_rail_enable;
    logic [1:0] full_scale_select;
    logic wideband_flat_enable;
    logic direct_bypass;
    logic mirror_pcm_settings;
    logic playback_power_down;
  } ctrl_word_t;

  // Status word
  typedef struct packed {
    logic [26:0] unused;
    logic bs_auto_muted;
    logic pcm_auto_muted;
    logic bs_ramp_busy;
    logic pcm_ramp_busy;
    logic power_down_done_event;
  } status_word_t;

  typedef enum logic [1:0] {FILT_IDLE, FILT_DOWN, FILT_UP} filt_state_t;

endpackage

// File: sig_ctl_if.sv
`timescale 1ns/10ps
interface sig_ctl_if;
  import sig_ctl_pkg::*;
  ctrl_word_t ctrl;
  path_ctl_t pcm_ctl;
  path_ctl_t bs_ctl;
  status_word_t status;

  modport device (input ctrl, input pcm_ctl, input bs_ctl, output status);
  modport host (output ctrl, output pcm_ctl, output bs_ctl, input status);
endinterface

// File: sig_ctl_host.sv
`timescale 1ns/10ps
`include "sig_ctl_params.svh"
module sig_ctl_host #(
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  sig_ctl_if.host link,
  input wire logic sample_rate_192k,
  output logic serial_ports_down,
  output logic bitstream_if_down
);
  import sig_ctl_pkg::*;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) r[8*k +: 8] = nw[8*k +: 8];
    end
    return r;
  endfunction

  ctrl_word_t ctrl_reg;
  path_ctl_t pcm_reg;
  path_ctl_t bs_reg;
  ctrl_word_t ctrl_out_reg;
  path_ctl_t pcm_out_reg;
  path_ctl_t bs_out_reg;
  ctrl_word_t ctrl_next;
  path_ctl_t pcm_next;
  path_ctl_t bs_next;
  logic [1:0] ports_reg;

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire [7:0] adr = 8'(wb_adr_i);
  wire hit_ctrl = adr == `REG_CTRL;
  wire hit_pcm = adr == `REG_PCM;
  wire hit_bs = adr == `REG_BS;
  wire hit_status = adr == `REG_STATUS;
  wire hit_ports = adr == `REG_PORTS;
  wire [31:0] rd_data = hit_ctrl ? 32'(ctrl_reg) : hit_pcm ? 32'(pcm_reg)
                      : hit_bs ? 32'(bs_reg) : hit_status ? 32'(link.status)
                      : hit_ports ? {30'h0000_0000, ports_reg} : 32'h0000_0000;
  wire [31:0] ports_wr = merge({30'h0000_0000, ports_reg}, wb_dat_i, wb_sel_i);

  // Chain settings pass only while powered down on both sides
  wire chain_open = ctrl_reg.playback_power_down & ctrl_out_reg.playback_power_down;
  // Port power-down needs the device to report done
  wire ports_ok = ctrl_out_reg.playback_power_down & link.status.power_down_done_event;

  // Propagation to the device; volume, mute and filter always live
  always_comb begin
    ctrl_next = chain_open ? ctrl_reg : ctrl_out_reg;
    ctrl_next.wideband_flat_enable = chain_open ? (ctrl_reg.wideband_flat_enable
        & sample_rate_192k & (ctrl_reg.filter_select != `NON_OVERSAMPLING_FILTER))
        : ctrl_out_reg.wideband_flat_enable;
    ctrl_next.playback_power_down = ctrl_reg.playback_power_down;
    ctrl_next.filter_select = ctrl_reg.filter_select;
    ctrl_next.pcm_ramp_down_enable = ctrl_reg.pcm_ramp_down_enable;
    pcm_next = chain_open ? pcm_reg : pcm_out_reg;
    pcm_next.volume_a = pcm_reg.volume_a;
    pcm_next.volume_b = pcm_reg.volume_b;
    pcm_next.mute_a = pcm_reg.mute_a;
    pcm_next.mute_b = pcm_reg.mute_b;
    bs_next = chain_open ? bs_reg : bs_out_reg;
    bs_next.volume_a = bs_reg.volume_a;
    bs_next.volume_b = bs_reg.volume_b;
    bs_next.mute_a = bs_reg.mute_a;
    bs_next.mute_b = bs_reg.mute_b;
  end

  // Register writes and bus answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= ctrl_word_t'(`CTRL_RESET);
      pcm_reg <= path_ctl_t'(`PATH_RESET);
      bs_reg <= path_ctl_t'(`PATH_RESET);
      ports_reg <= `PORTS_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) wb_dat_o <= rd_data;
      if (wr & hit_ctrl) ctrl_reg <= ctrl_word_t'(merge(ctrl_reg, wb_dat_i, wb_sel_i));
      if (wr & hit_pcm) pcm_reg <= path_ctl_t'(merge(pcm_reg, wb_dat_i, wb_sel_i));
      if (wr & hit_bs) bs_reg <= path_ctl_t'(merge(bs_reg, wb_dat_i, wb_sel_i));
      if (wr & hit_ports) ports_reg <= ports_wr[1:0] & (ports_ok ? 2'h3 : ports_reg);
    end
  end

  // Device-facing and user-facing outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_out_reg <= ctrl_word_t'(`CTRL_RESET);
      pcm_out_reg <= path_ctl_t'(`PATH_RESET);
      bs_out_reg <= path_ctl_t'(`PATH_RESET);
      serial_ports_down <= 1'b0;
      bitstream_if_down <= 1'b0;
    end else begin
      ctrl_out_reg <= ctrl_next;
      pcm_out_reg <= pcm_next;
      bs_out_reg <= bs_next;
      serial_ports_down <= ports_reg[0];
      bitstream_if_down <= ports_reg[1];
    end
  end

  assign link.ctrl = ctrl_out_reg;
  assign link.pcm_ctl = pcm_out_reg;
  assign link.bs_ctl = bs_out_reg;

endmodule // sig_ctl_host

// File: sig_ctl_properties.sv
`timescale 1ns/10ps
module sig_ctl_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire sig_ctl_pkg::ctrl_word_t ctrl,
  input wire sig_ctl_pkg::path_ctl_t pcm_ctl,
  input wire sig_ctl_pkg::path_ctl_t bs_ctl,
  input wire sig_ctl_pkg::status_word_t status
);
  import sig_ctl_pkg::*;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Link words right after reset release
  a_reset_defaults: assert property ($fell(rst) |-> ctrl == 32'h0000_0001
    && pcm_ctl == '0 && bs_ctl == '0 && status == '0)
    else $error("link words not at defaults after reset");
  // Done event only follows an applied power-down
  a_done_needs_pdn: assert property (status.power_down_done_event
    |-> $past(ctrl.playback_power_down))
    else $error("done event without power-down");
  a_done_clears: assert property ($fell(ctrl.playback_power_down)
    |-> ##[1:2] !status.power_down_done_event)
    else $error("done event stuck after power-up");
  // Chain settings move only while playback is down
  a_wideband_gated: assert property ($changed(ctrl.wideband_flat_enable)
    |-> $past(ctrl.playback_power_down))
    else $error("wideband changed during playback");
  a_mode_gated: assert property ($changed({ctrl.mirror_pcm_settings,
    ctrl.direct_bypass, ctrl.full_scale_select}) |-> $past(ctrl.playback_power_down))
    else $error("chain mode changed during playback");
  a_pcm_chain_gated: assert property ($changed({pcm_ctl.invert_channel_a,
    pcm_ctl.invert_channel_b, pcm_ctl.swap_channels, pcm_ctl.copy_a_to_b})
    |-> $past(ctrl.playback_power_down))
    else $error("pcm routing changed during playback");
  a_bs_chain_gated: assert property ($changed({bs_ctl.invert_channel_a,
    bs_ctl.invert_channel_b, bs_ctl.swap_channels, bs_ctl.copy_a_to_b})
    |-> $past(ctrl.playback_power_down))
    else $error("bitstream routing changed during playback");
  // A new target in soft mode starts a ramp promptly
  a_ramp_starts: assert property ($changed(pcm_ctl.volume_a)
    && pcm_ctl.volume_change_mode == 2'h2 && !ctrl.playback_power_down
    |-> ##[1:3] status.pcm_ramp_busy)
    else $error("soft ramp did not start");

  c_ramp: cover property (status.pcm_ramp_busy);
  c_auto_mute: cover property (status.pcm_auto_muted);
  c_done: cover property ($rose(status.power_down_done_event));
endmodule // sig_ctl_properties

// File: tb_audio_volume_signal_control.sv
`timescale 1ns/10ps
`include "sig_ctl_params.svh"
module tb_audio_volume_signal_control;
  import sig_ctl_pkg::*;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic rate_192k = 1'b1;
  logic [1:0] ports_down;
  logic pcm_valid = 1'b0;
  logic signed [23:0] pcm_a = 24'h0;
  logic signed [23:0] pcm_b = 24'h0;
  logic bs_valid = 1'b0;
  logic bs_a = 1'b0;
  logic bs_b = 1'b0;
  logic bs_err = 1'b0;
  logic out_valid, bs_out_valid, direct_valid, direct_a, direct_b, boost, wideband;
  logic signed [23:0] out_a, out_b, bs_out_a, bs_out_b;
  logic [1:0] fs_level, filt;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int ramp_n = 0;
  // Rows: pcm word, in a, in b, expected a, expected b
  localparam logic [127:0] ROWS [10] = '{
    {32'h0000_0000, 24'h10_0000, 24'h20_0000, 24'h10_0000, 24'h20_0000},
    {32'h0000_000C, 24'h10_0000, 24'h20_0000, 24'h08_0000, 24'h20_0000},
    {32'h0001_000C, 24'h10_0000, 24'h20_0000, 24'h08_0000, 24'h10_0000},
    {32'h0008_0000, 24'h10_0000, 24'h20_0000, 24'h00_0000, 24'h20_0000},
    {32'h0010_0000, 24'h10_0000, 24'h20_0000, 24'h10_0000, 24'h00_0000},
    {32'h0020_0000, 24'h10_0000, 24'h20_0000, 24'hF0_0000, 24'h20_0000},
    {32'h0040_0000, 24'h10_0000, 24'h20_0000, 24'h10_0000, 24'hE0_0000},
    {32'h0080_0000, 24'h10_0000, 24'h20_0000, 24'h20_0000, 24'h10_0000},
    {32'h0100_0000, 24'h10_0000, 24'h20_0000, 24'h10_0000, 24'h10_0000},
    {32'h0000_18FE, 24'h10_0000, 24'h20_0000, 24'h00_0000, 24'h08_0000}};

  sig_ctl_if i_sig_ctl_if ();
  sig_ctl_host #(.AW(8)) i_sig_ctl_host (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(i_sig_ctl_if),
    .sample_rate_192k(rate_192k), .serial_ports_down(ports_down[0]),
    .bitstream_if_down(ports_down[1]));
  // Short step and mute counts keep ramps inside the run
  sig_ctl_device #(.STEP_CYCLES(4), .MUTE_SAMPLES(8)) i_sig_ctl_device (.core_clk(core_clk),
    .rst(rst), .link(i_sig_ctl_if), .pcm_valid(pcm_valid), .pcm_a(pcm_a), .pcm_b(pcm_b),
    .bs_valid(bs_valid), .bs_a(bs_a), .bs_b(bs_b), .bs_error(bs_err), .out_valid(out_valid),
    .out_a(out_a), .out_b(out_b), .bs_out_valid(bs_out_valid), .bs_out_a(bs_out_a),
    .bs_out_b(bs_out_b), .direct_valid(direct_valid), .direct_a(direct_a),
    .direct_b(direct_b), .full_scale_level(fs_level), .boost_active(boost),
    .wideband_active(wideband), .filter_active(filt));
  sig_ctl_properties i_sig_ctl_properties (.core_clk(core_clk), .rst(rst),
    .ctrl(i_sig_ctl_if.ctrl), .pcm_ctl(i_sig_ctl_if.pcm_ctl), .bs_ctl(i_sig_ctl_if.bs_ctl),
    .status(i_sig_ctl_if.status));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the longest filter ramp
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge core_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask

  // Chain settings only land while powered down, so power down around them
  task automatic cfg(input logic [31:0] c, input logic [31:0] p, input logic [31:0] s);
    wr(`REG_CTRL, c | 32'h0000_0001);
    settle();
    wr(`REG_PCM, p);
    wr(`REG_BS, s);
    wr(`REG_CTRL, c);
    settle();
  endtask

  task automatic pcm(input logic [23:0] a, input logic [23:0] b, input logic v,
                     input logic [23:0] ea, input logic [23:0] eb);
    @(posedge core_clk);
    pcm_valid <= 1'b1;
    pcm_a <= a;
    pcm_b <= b;
    @(posedge core_clk);
    pcm_valid <= 1'b0;
    @(posedge core_clk);
    check(out_valid, v);
    if (v) check({8'h00, out_a}, ea);
    if (v) check({8'h00, out_b}, eb);
  endtask

  task automatic bs(input logic a, input logic b);
    @(posedge core_clk);
    bs_valid <= 1'b1;
    bs_a <= a;
    bs_b <= b;
    @(posedge core_clk);
    bs_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wait_idle();
    ramp_n = 0;
    while (i_sig_ctl_if.status.pcm_ramp_busy !== 1'b0 && ramp_n < 10000) begin
      @(posedge core_clk);
      ramp_n++;
    end
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    rdchk(`REG_CTRL, `CTRL_RESET);
    rdchk(`REG_PCM, `PATH_RESET);
    rdchk(`REG_BS, `PATH_RESET);
    rdchk(8'h20, 32'h0);
    rdchk(`REG_STATUS, 32'h0000_0001);
    wr(`REG_PORTS, 32'h3);
    rdchk(`REG_PORTS, 32'h3);
    check(ports_down, 2'h3);
    wr(`REG_PORTS, 32'h0);
    for (int i = 0; i < 10; i++) begin
      cfg(32'h0, ROWS[i][127:96], 32'h0);
      pcm(ROWS[i][95:72], ROWS[i][71:48], 1'b1, ROWS[i][47:24], ROWS[i][23:0]);
    end
    // Ports stay up while playback runs
    wr(`REG_PORTS, 32'h3);
    rdchk(`REG_PORTS, 32'h0);
    wr(`REG_CTRL, 32'h0000_0001);
    settle();
    pcm(24'h10_0000, 24'h10_0000, 1'b0, 24'h0, 24'h0);
    // Full scale, boost and wideband
    cfg(32'h0000_00F8, 32'h0, 32'h0);
    check(fs_level, 2'h3);
    check(boost, 1'b1);
    check(wideband, 1'b1);
    cfg(32'h0000_00E8, 32'h0, 32'h0);
    check(boost, 1'b0);
    rate_192k <= 1'b0;
    cfg(32'h0000_0008, 32'h0, 32'h0);
    check(wideband, 1'b0);
    // Mirror takes the pcm invert, own bits otherwise
    cfg(32'h0000_0002, 32'h0040_0000, 32'h0);
    bs(1'b1, 1'b1);
    check(bs_out_valid, 1'b1);
    check({8'h00, bs_out_a}, 32'h0040_0000);
    check({8'h00, bs_out_b}, 32'h00C0_0000);
    cfg(32'h0, 32'h0040_0000, 32'h0);
    bs(1'b1, 1'b1);
    check({8'h00, bs_out_b}, 32'h0040_0000);
    cfg(32'h0000_0004, 32'h0, 32'h0);
    bs(1'b1, 1'b0);
    check({bs_out_valid, direct_valid, direct_a, direct_b}, 32'h6);
    // Auto-mute after a run of zero pairs
    cfg(32'h0, 32'h0200_0000, 32'h0);
    repeat (10) pcm(24'h0, 24'h0, 1'b1, 24'h0, 24'h0);
    rdchk(`REG_STATUS, 32'h0000_0008);
    // Soft ramp, retarget mid-way, then timed ramp back to 0 dB
    cfg(32'h0, 32'h0004_0000, 32'h0);
    wr(`REG_PCM, 32'h0004_0018);
    repeat (20) @(posedge core_clk);
    rdchk(`REG_STATUS, 32'h0000_0002);
    wr(`REG_PCM, 32'h0004_000C);
    repeat (3) @(posedge core_clk);
    wait_idle();
    pcm(24'h10_0000, 24'h20_0000, 1'b1, 24'h08_0000, 24'h20_0000);
    wr(`REG_PCM, 32'h0004_0000);
    repeat (3) @(posedge core_clk);
    wait_idle();
    check({31'h0, ramp_n >= 180 && ramp_n <= 200}, 32'h1);
    pcm(24'h10_0000, 24'h20_0000, 1'b1, 24'h10_0000, 24'h20_0000);
    // Filter change ramps down before switching
    cfg(32'h0000_0100, 32'h0, 32'h0);
    wr(`REG_CTRL, 32'h0000_0900);
    repeat (20) @(posedge core_clk);
    check(filt, 2'h0);
    wait_idle();
    check(filt, 2'h2);
    check({31'h0, ramp_n > 3000}, 32'h1);
    repeat (3) @(posedge core_clk);
    wait_idle();
    wr(`REG_CTRL, 32'h0000_0400);
    settle();
    check(filt, 2'h1);
    // Stream error floors the bitstream path, then it ramps back
    cfg(32'h0000_0200, 32'h0, 32'h0);
    bs_err <= 1'b1;
    bs(1'b1, 1'b1);
    check(bs_out_a, 32'h0);
    bs_err <= 1'b0;
    repeat (20) @(posedge core_clk);
    rdchk(`REG_STATUS, 32'h0000_0004);
    final_report();
  end
endmodule // tb_audio_volume_signal_control
